/* File: pfc_map.svh */
// pfc_map.svh: named constants for the pin function and run clock block.
// assumes inclusion by bare name from every file that needs them.
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH

// port numbers within the pin arrays
`define PFC_P0 3'h0
`define PFC_P1 3'h1
`define PFC_P2 3'h2
`define PFC_P3 3'h3
`define PFC_P4 3'h4
`define PFC_P5 3'h5
`define PFC_P6 3'h6
`define PFC_P7 3'h7

// bit positions of single-function pins
`define PFC_B0 3'h0
`define PFC_B1 3'h1
`define PFC_B2 3'h2
`define PFC_B3 3'h3
`define PFC_B4 3'h4
`define PFC_B5 3'h5
`define PFC_B6 3'h6
`define PFC_B7 3'h7

// reset and idle values
`define PFC_BYTE_RST 8'h00
`define PFC_P7_RST 8'hff
`define PFC_ADDR_IDLE 24'hffffff
`define PFC_DATA_IDLE 8'hff
`define PFC_ALL_OUT 8'hff
`define PFC_ALL_IN 8'h00

// oscillator settling time and its cycle count at the reference rate
`define PFC_SETTLE_MS 100
`define PFC_REF_KHZ 125000
`define PFC_SETTLE_CYCLES (`PFC_SETTLE_MS * `PFC_REF_KHZ)

`endif

/* File: pfc_pkg.sv */
// pfc_pkg: types shared by the pin function and run clock block.
// assumes the constants of pfc_map.svh are included where they are used.
package pfc_pkg;

	// control bits that steer pin functions and clocks
	typedef struct packed {
		logic ext_bus_select;
		logic emulation_trace_select;
		logic p40_alt_enable;
		logic p40_nonmask_choice;
		logic [3:0] serial_rx_pin_enable;
		logic [3:0] serial_tx_pin_enable;
		logic timer_input_pin_enable;
		logic timer_output_pin_enable;
		logic timer_output1_pin_enable;
		logic pwm_enable_a;
		logic pwm_enable_b;
		logic tone0_pin_enable;
		logic tone1_pin_enable;
		logic edge_enable_bit0;
		logic edge_enable_bit1;
		logic edge_enable_bit2;
		logic level_irq_pin_enable;
		logic edge_enable_bit4;
		logic edge_enable_bit5;
		logic host_port_enable;
		logic host_port_strobe_mode;
		logic [7:0] chip_select_enable;
		logic fast_osc_run_bit;
		logic clock_source_select;
	} pfc_ctrl_t;

	// signals from the core and peripherals toward the pins
	typedef struct packed {
		logic [23:0] addr;
		logic [7:0] data_out;
		logic data_oe;
		logic mem_write;
		logic ext_access;
		logic opcode_fetch;
		logic [7:0] chip_select_n;
		logic [3:0] serial_transmit;
		logic timer_event_out;
		logic timer_event_out1;
		logic tone_out_0;
		logic tone_out_1;
		logic host_interrupt_n;
		logic [7:0] host_data_out;
		logic host_data_oe;
		logic wait_for_interrupt_instr;
		logic halt_instr;
		logic irq_wake;
	} pfc_core_t;

	// signals from the pins toward the core and peripherals
	typedef struct packed {
		logic [3:0] serial_receive;
		logic timer_event_in;
		logic pwm_in;
		logic rising_edge_irq_in;
		logic rising_edge_irq_p60;
		logic [2:0] falling_edge_irq_in;
		logic nonmaskable_irq_n;
		logic abort_in_n;
		logic level_irq_n;
		logic host_write_enable_n;
		logic host_select_n;
		logic host_write_strobe_n;
		logic host_read_strobe_n;
		logic [2:0] host_reg_select;
		logic [7:0] host_data_in;
		logic [7:0] bus_data_in;
		logic [15:0] dma_addr;
		logic dma_write_n;
	} pfc_alt_in_t;

	typedef enum logic [2:0] {
		PFC_RUN = 3'b001,
		PFC_WAIT = 3'b010,
		PFC_STOP = 3'b100
	} pfc_act_t;

endpackage : pfc_pkg

/* File: pfc_clk_sel.sv */
// pfc_clk_sel: glitch-free choice of the system phase clock source.
// assumes slow and fast clock levels arrive synchronous to ref_clk_i.
`timescale 1ns/1ns
`include "pfc_map.svh"

module pfc_clk_sel (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic slow_clk_i,
	input wire logic fast_clk_i,
	input wire logic select_fast_i,
	input wire logic halt_i,
	output logic phase_clk_o,
	output logic using_fast_o
);

	logic next_phase_clk;
	logic next_using_fast;
	logic src;

	always_comb begin
		next_using_fast = using_fast_o;
		src = using_fast_o ? fast_clk_i : slow_clk_i;
		next_phase_clk = src;
		// swap only while both old output and new source are low
		if (select_fast_i != using_fast_o && !phase_clk_o) begin
			if (!(select_fast_i ? fast_clk_i : slow_clk_i)) begin
				next_using_fast = select_fast_i;
				next_phase_clk = 1'b0;
			end else begin
				next_phase_clk = 1'b0;
			end
		end
		// a halted clock freezes once high, never mid-phase
		if (halt_i && phase_clk_o) begin
			next_phase_clk = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_clk_o <= 1'b0;
			using_fast_o <= 1'b0;
		end else begin
			phase_clk_o <= next_phase_clk;
			using_fast_o <= next_using_fast;
		end
	end

endmodule : pfc_clk_sel

/* File: pfc_pin_mux.sv */
// pfc_pin_mux: shared pin function selection, write strobe, activity pin
// and system clock source control.
// assumes all pin and control inputs are synchronous to ref_clk_i.
`timescale 1ns/1ns
`include "pfc_map.svh"

module pfc_pin_mux #(
	parameter int unsigned SETTLE_CYCLES = `PFC_SETTLE_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire pfc_pkg::pfc_ctrl_t ctrl_i,
	input wire pfc_pkg::pfc_core_t core_i,
	input wire logic [7:0][7:0] gpio_out_i,
	input wire logic [7:0][7:0] gpio_dir_i,
	input wire logic [7:0][7:0] pin_in_i,
	input wire logic bus_release_in_i,
	input wire logic slow_clk_i,
	input wire logic fast_clk_i,
	input wire logic write_strobe_n_i,
	output logic [7:0][7:0] pin_out_o,
	output logic [7:0][7:0] pin_oe_o,
	output logic [7:0][7:0] gpio_in_o,
	output pfc_pkg::pfc_alt_in_t alt_o,
	output logic [1:0] tone_pin_o,
	output logic write_strobe_n_o,
	output logic write_strobe_n_oe_o,
	output logic activity_o,
	output logic system_phase_clock_o,
	output logic fast_osc_o,
	output logic fast_osc_ready_o,
	output logic clock_restart_req_o,
	output logic cpu_halted_o,
	output logic boot_strap_o
);

	function automatic logic [7:0] sel8(input logic en, input logic [7:0] a,
		input logic [7:0] b);
		sel8 = en ? a : b;
	endfunction : sel8

	logic [7:0][7:0] next_pin_out;
	logic [7:0][7:0] next_pin_oe;
	pfc_pkg::pfc_alt_in_t next_alt;
	logic [1:0] next_tone;
	logic next_ws_n;
	logic next_ws_oe;
	logic next_activity;
	logic next_fast_osc;
	logic next_restart;
	logic next_halted;
	logic next_strap;
	logic next_boot_done;
	logic boot_done;
	pfc_pkg::pfc_act_t state;
	pfc_pkg::pfc_act_t next_state;
	logic [31:0] settle_cnt;
	logic [31:0] next_settle_cnt;
	logic next_ready;
	logic phase_clk;
	logic ext_bus;
	logic trace;
	logic [23:0] addr_val;
	logic [7:0] data_val;
	logic pwm_sel;
	logic running;

	pfc_clk_sel u_clk_sel (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.slow_clk_i(slow_clk_i),
		.fast_clk_i(fast_clk_i),
		.select_fast_i(ctrl_i.clock_source_select & fast_osc_o),
		.halt_i(state == pfc_pkg::PFC_STOP),
		.phase_clk_o(phase_clk),
		.using_fast_o()
	);

	// strap caught on the first clocked edge after reset release
	always_comb begin
		next_boot_done = 1'b1;
		next_strap = boot_done ? boot_strap_o : ~bus_release_in_i;
		ext_bus = ctrl_i.ext_bus_select | boot_strap_o;
		trace = ctrl_i.emulation_trace_select | boot_strap_o;
	end

	// activity state and clock control
	always_comb begin
		next_state = state;
		next_restart = 1'b0;
		case (state)
			pfc_pkg::PFC_RUN: begin
				if (phase_clk && core_i.halt_instr) begin
					next_state = pfc_pkg::PFC_STOP;
				end else if (phase_clk && core_i.wait_for_interrupt_instr) begin
					next_state = pfc_pkg::PFC_WAIT;
				end
			end
			pfc_pkg::PFC_WAIT: begin
				if (core_i.irq_wake) begin
					next_state = pfc_pkg::PFC_RUN;
					next_restart = 1'b1;
				end
			end
			pfc_pkg::PFC_STOP: next_state = pfc_pkg::PFC_STOP;
			default: next_state = pfc_pkg::PFC_RUN;
		endcase
		// reset release also counts as a restart
		if (!boot_done) begin
			next_restart = 1'b1;
		end
		running = (next_state == pfc_pkg::PFC_RUN);
		next_halted = ~running;
		// bus release is deliberately not a term here
		if (trace && !phase_clk) begin
			next_activity = core_i.opcode_fetch;
		end else begin
			next_activity = running;
		end
		next_fast_osc = ctrl_i.fast_osc_run_bit;
		// settle timer only advises; selection is never blocked by it
		if (!ctrl_i.fast_osc_run_bit) begin
			next_settle_cnt = '0;
		end else if (settle_cnt < SETTLE_CYCLES) begin
			next_settle_cnt = settle_cnt + 32'h1;
		end else begin
			next_settle_cnt = settle_cnt;
		end
		next_ready = ctrl_i.fast_osc_run_bit &&
			(settle_cnt >= SETTLE_CYCLES);
	end

	// pin function multiplexing
	always_comb begin
		next_alt = '0;
		for (int p = 0; p < 8; p++) begin
			next_pin_out[p] = gpio_out_i[p];
			next_pin_oe[p] = gpio_dir_i[p];
		end
		// on-chip cycles idle the bus high unless traced
		addr_val = (core_i.ext_access | trace) ? core_i.addr : `PFC_ADDR_IDLE;
		data_val = (core_i.ext_access | trace) ? core_i.data_out :
			`PFC_DATA_IDLE;
		if (ext_bus) begin
			next_pin_out[`PFC_P0] = addr_val[7:0];
			next_pin_out[`PFC_P1] = addr_val[15:8];
			next_pin_out[`PFC_P3] = addr_val[23:16];
			// released bus turns the address pins round for dma
			next_pin_oe[`PFC_P0] = sel8(bus_release_in_i, `PFC_ALL_OUT,
				`PFC_ALL_IN);
			next_pin_oe[`PFC_P1] = sel8(bus_release_in_i, `PFC_ALL_OUT,
				`PFC_ALL_IN);
			next_pin_oe[`PFC_P3] = sel8(bus_release_in_i, `PFC_ALL_OUT,
				`PFC_ALL_IN);
			next_pin_out[`PFC_P2] = data_val;
			next_pin_oe[`PFC_P2] = sel8(core_i.data_oe & bus_release_in_i,
				`PFC_ALL_OUT, `PFC_ALL_IN);
		end
		next_alt.bus_data_in = pin_in_i[`PFC_P2];
		next_alt.dma_addr = {pin_in_i[`PFC_P1], pin_in_i[`PFC_P0]};
		// port 7 is output only
		next_pin_out[`PFC_P7] = (ctrl_i.chip_select_enable &
			core_i.chip_select_n) | (~ctrl_i.chip_select_enable &
			gpio_out_i[`PFC_P7]);
		next_pin_oe[`PFC_P7] = `PFC_ALL_OUT;
		// port 6: even pins receive, odd pins transmit
		for (int c = 0; c < 4; c++) begin
			next_alt.serial_receive[c] = ctrl_i.serial_rx_pin_enable[c] ?
				pin_in_i[`PFC_P6][2*c] : 1'b1;
			if (ctrl_i.serial_rx_pin_enable[c]) begin
				next_pin_oe[`PFC_P6][2*c] = 1'b0;
			end
			if (ctrl_i.serial_tx_pin_enable[c]) begin
				next_pin_out[`PFC_P6][2*c+1] = core_i.serial_transmit[c];
				next_pin_oe[`PFC_P6][2*c+1] = 1'b1;
			end
		end
		if (ctrl_i.timer_input_pin_enable || ctrl_i.edge_enable_bit2) begin
			next_pin_oe[`PFC_P6][`PFC_B0] = 1'b0;
		end
		next_alt.timer_event_in = ctrl_i.timer_input_pin_enable &
			pin_in_i[`PFC_P6][`PFC_B0];
		next_alt.rising_edge_irq_p60 = ctrl_i.edge_enable_bit2 &
			pin_in_i[`PFC_P6][`PFC_B0];
		// timer output outranks serial transmit on its pin
		if (ctrl_i.timer_output_pin_enable) begin
			next_pin_out[`PFC_P6][`PFC_B1] = core_i.timer_event_out;
			next_pin_oe[`PFC_P6][`PFC_B1] = 1'b1;
		end
		if (ctrl_i.timer_output1_pin_enable) begin
			next_pin_out[`PFC_P6][`PFC_B3] = core_i.timer_event_out1;
			next_pin_oe[`PFC_P6][`PFC_B3] = 1'b1;
		end
		pwm_sel = ctrl_i.pwm_enable_a & ctrl_i.pwm_enable_b;
		if (pwm_sel) begin
			next_pin_oe[`PFC_P6][`PFC_B2] = 1'b0;
			next_alt.serial_receive[1] = 1'b1;
		end
		next_alt.pwm_in = pwm_sel & pin_in_i[`PFC_P6][`PFC_B2];
		// edge inputs: idle low for rising, idle high for falling
		next_alt.rising_edge_irq_in = ctrl_i.edge_enable_bit0 &
			pin_in_i[`PFC_P5][`PFC_B6];
		next_alt.falling_edge_irq_in[0] = ~ctrl_i.edge_enable_bit1 |
			pin_in_i[`PFC_P5][`PFC_B7];
		next_alt.falling_edge_irq_in[1] = ~ctrl_i.edge_enable_bit4 |
			pin_in_i[`PFC_P6][`PFC_B4];
		next_alt.falling_edge_irq_in[2] = ~ctrl_i.edge_enable_bit5 |
			pin_in_i[`PFC_P6][`PFC_B6];
		if (ctrl_i.edge_enable_bit0) begin
			next_pin_oe[`PFC_P5][`PFC_B6] = 1'b0;
		end
		if (ctrl_i.edge_enable_bit1) begin
			next_pin_oe[`PFC_P5][`PFC_B7] = 1'b0;
		end
		if (ctrl_i.edge_enable_bit4) begin
			next_pin_oe[`PFC_P6][`PFC_B4] = 1'b0;
		end
		if (ctrl_i.edge_enable_bit5) begin
			next_pin_oe[`PFC_P6][`PFC_B6] = 1'b0;
		end
		// P40 and P41 interrupt inputs, inactive high when unselected
		next_alt.nonmaskable_irq_n = ~(ctrl_i.p40_alt_enable &
			ctrl_i.p40_nonmask_choice) | pin_in_i[`PFC_P4][`PFC_B0];
		next_alt.abort_in_n = ~(ctrl_i.p40_alt_enable &
			~ctrl_i.p40_nonmask_choice) | pin_in_i[`PFC_P4][`PFC_B0];
		if (ctrl_i.p40_alt_enable) begin
			next_pin_oe[`PFC_P4][`PFC_B0] = 1'b0;
		end
		next_alt.level_irq_n = ~ctrl_i.level_irq_pin_enable |
			pin_in_i[`PFC_P4][`PFC_B1];
		if (ctrl_i.level_irq_pin_enable) begin
			next_pin_oe[`PFC_P4][`PFC_B1] = 1'b0;
		end
		// host port outranks gpio and edge pin directions on P42-P57
		next_alt.host_write_enable_n = 1'b1;
		next_alt.host_select_n = 1'b1;
		next_alt.host_write_strobe_n = 1'b1;
		next_alt.host_read_strobe_n = 1'b1;
		if (ctrl_i.host_port_enable) begin
			next_pin_out[`PFC_P4][`PFC_B2] = core_i.host_interrupt_n;
			next_pin_oe[`PFC_P4][`PFC_B2] = 1'b1;
			next_pin_oe[`PFC_P4][7:3] = 5'h00;
			next_pin_out[`PFC_P5] = core_i.host_data_out;
			next_pin_oe[`PFC_P5] = sel8(core_i.host_data_oe, `PFC_ALL_OUT,
				`PFC_ALL_IN);
			next_alt.host_reg_select = pin_in_i[`PFC_P4][7:5];
			next_alt.host_data_in = pin_in_i[`PFC_P5];
			if (ctrl_i.host_port_strobe_mode) begin
				next_alt.host_write_strobe_n = pin_in_i[`PFC_P4][`PFC_B3];
				next_alt.host_read_strobe_n = pin_in_i[`PFC_P4][`PFC_B4];
			end else begin
				next_alt.host_write_enable_n = pin_in_i[`PFC_P4][`PFC_B3];
				next_alt.host_select_n = pin_in_i[`PFC_P4][`PFC_B4];
			end
		end
		next_tone[0] = ctrl_i.tone0_pin_enable & core_i.tone_out_0;
		next_tone[1] = ctrl_i.tone1_pin_enable & core_i.tone_out_1;
		// write strobe and its turnaround
		next_ws_n = ~(core_i.mem_write & core_i.ext_access);
		next_ws_oe = bus_release_in_i;
		next_alt.dma_write_n = bus_release_in_i | write_strobe_n_i;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int p = 0; p < 8; p++) begin
				pin_out_o[p] <= `PFC_BYTE_RST;
				pin_oe_o[p] <= `PFC_ALL_IN;
				gpio_in_o[p] <= `PFC_BYTE_RST;
			end
			pin_out_o[`PFC_P7] <= `PFC_P7_RST;
			pin_oe_o[`PFC_P7] <= `PFC_ALL_OUT;
			alt_o <= '0;
			tone_pin_o <= 2'h0;
			write_strobe_n_o <= 1'b1;
			write_strobe_n_oe_o <= 1'b0;
			activity_o <= 1'b0;
			system_phase_clock_o <= 1'b0;
			fast_osc_o <= 1'b0;
			fast_osc_ready_o <= 1'b0;
			clock_restart_req_o <= 1'b0;
			cpu_halted_o <= 1'b1;
			boot_strap_o <= 1'b0;
			boot_done <= 1'b0;
			state <= pfc_pkg::PFC_RUN;
			settle_cnt <= '0;
		end else begin
			pin_out_o <= next_pin_out;
			pin_oe_o <= next_pin_oe;
			gpio_in_o <= pin_in_i;
			alt_o <= next_alt;
			tone_pin_o <= next_tone;
			write_strobe_n_o <= next_ws_n;
			write_strobe_n_oe_o <= next_ws_oe;
			activity_o <= next_activity;
			system_phase_clock_o <= phase_clk;
			fast_osc_o <= next_fast_osc;
			fast_osc_ready_o <= next_ready;
			clock_restart_req_o <= next_restart;
			cpu_halted_o <= next_halted;
			boot_strap_o <= next_strap;
			boot_done <= next_boot_done;
			state <= next_state;
			settle_cnt <= next_settle_cnt;
		end
	end

endmodule : pfc_pin_mux

/* File: pfc_pin_mux_chk.sv */
// pfc_pin_mux_chk: port-level checks for pfc_pin_mux.
// assumes a bind onto every pfc_pin_mux instance, one reference clock.
`timescale 1ns/1ns
module pfc_pin_mux_chk (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire pfc_pkg::pfc_ctrl_t ctrl_i,
	input wire pfc_pkg::pfc_core_t core_i,
	input wire logic [7:0][7:0] gpio_out_i,
	input wire logic bus_release_in_i,
	input wire logic slow_clk_i,
	input wire logic fast_clk_i,
	input wire logic [7:0][7:0] pin_out_o,
	input wire logic [7:0][7:0] pin_oe_o,
	input wire logic [1:0] tone_pin_o,
	input wire logic write_strobe_n_o,
	input wire logic write_strobe_n_oe_o,
	input wire logic activity_o,
	input wire logic system_phase_clock_o,
	input wire logic fast_osc_o,
	input wire logic clock_restart_req_o,
	input wire logic cpu_halted_o,
	input wire logic boot_strap_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic quiet;
	logic slow_ok;
	logic fast_ok;
	// trace mode muxes the fetch flag onto the activity pin in low phases
	assign quiet = !ctrl_i.emulation_trace_select && !boot_strap_o;
	assign slow_ok = !ctrl_i.clock_source_select && !cpu_halted_o
		&& !core_i.halt_instr;
	assign fast_ok = ctrl_i.clock_source_select && fast_osc_o
		&& !cpu_halted_o && !core_i.halt_instr;
	sequence s_wait;
		core_i.wait_for_interrupt_instr ##1 $rose(cpu_halted_o);
	endsequence
	sequence s_stop;
		quiet && core_i.halt_instr ##1 $rose(cpu_halted_o);
	endsequence
	property p_addr_pins;
		ctrl_i.ext_bus_select && bus_release_in_i |=> pin_oe_o[0] == 8'hff
			&& pin_oe_o[1] == 8'hff && pin_oe_o[3] == 8'hff;
	endproperty
	a_addr_pins: assert property (p_addr_pins)
		else $error("address pins not driven");
	property p_chip_sel;
		1 |=> pin_out_o[7] == $past(ctrl_i.chip_select_enable
			& core_i.chip_select_n | ~ctrl_i.chip_select_enable & gpio_out_i[7]);
	endproperty
	a_chip_sel: assert property (p_chip_sel)
		else $error("port 7 value wrong");
	property p_tone;
		1 |=> tone_pin_o == $past({ctrl_i.tone1_pin_enable & core_i.tone_out_1,
			ctrl_i.tone0_pin_enable & core_i.tone_out_0});
	endproperty
	a_tone: assert property (p_tone)
		else $error("tone pins wrong");
	property p_strobe_idle;
		bus_release_in_i && !(core_i.mem_write && core_i.ext_access)
			|=> write_strobe_n_o && write_strobe_n_oe_o;
	endproperty
	a_strobe_idle: assert property (p_strobe_idle)
		else $error("write strobe not held high");
	property p_strobe_low;
		bus_release_in_i && core_i.mem_write && core_i.ext_access
			|=> !write_strobe_n_o;
	endproperty
	a_strobe_low: assert property (p_strobe_low)
		else $error("write strobe not low on external write");
	property p_strobe_in;
		!bus_release_in_i |=> !write_strobe_n_oe_o;
	endproperty
	a_strobe_in: assert property (p_strobe_in)
		else $error("write strobe driven while released");
	property p_stop;
		s_stop |=> (cpu_halted_o && !activity_o) [*8];
	endproperty
	a_stop: assert property (p_stop)
		else $error("halt state left early");
	property p_wake;
		s_wait ##[1:40] core_i.irq_wake |=> !cpu_halted_o && clock_restart_req_o;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wait not ended by interrupt");
	property p_osc;
		1 |=> fast_osc_o == $past(ctrl_i.fast_osc_run_bit);
	endproperty
	a_osc: assert property (p_osc)
		else $error("oscillator enable wrong");
	property p_slow;
		slow_ok [*8] ##1 slow_ok [*8]
			|-> ##2 system_phase_clock_o == $past(slow_clk_i, 2);
	endproperty
	a_slow: assert property (p_slow)
		else $error("phase clock not from slow input");
	property p_fast;
		fast_ok [*8] ##1 fast_ok [*8]
			|-> ##2 system_phase_clock_o == $past(fast_clk_i, 2);
	endproperty
	a_fast: assert property (p_fast)
		else $error("phase clock not from fast input");
	property p_activity;
		quiet |=> activity_o == !cpu_halted_o;
	endproperty
	a_activity: assert property (p_activity)
		else $error("activity pin wrong");
endmodule : pfc_pin_mux_chk

bind pfc_pin_mux pfc_pin_mux_chk i_chk (.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i), .ctrl_i(ctrl_i), .core_i(core_i),
	.gpio_out_i(gpio_out_i), .bus_release_in_i(bus_release_in_i),
	.slow_clk_i(slow_clk_i), .fast_clk_i(fast_clk_i), .pin_out_o(pin_out_o),
	.pin_oe_o(pin_oe_o), .tone_pin_o(tone_pin_o),
	.write_strobe_n_o(write_strobe_n_o),
	.write_strobe_n_oe_o(write_strobe_n_oe_o), .activity_o(activity_o),
	.system_phase_clock_o(system_phase_clock_o), .fast_osc_o(fast_osc_o),
	.clock_restart_req_o(clock_restart_req_o), .cpu_halted_o(cpu_halted_o),
	.boot_strap_o(boot_strap_o));

/* File: pfc_far_side.sv */
// pfc_far_side: oscillators, pin loads and the emulator's strobe driver.
// assumes levels change just after rising edges of ref_clk_i.
`timescale 1ns/1ns
module pfc_far_side (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic fast_osc_i,
	input wire logic bus_release_in_i,
	input wire logic dma_write_n_i,
	input wire logic [7:0][7:0] pin_out_i,
	input wire logic [7:0][7:0] pin_oe_i,
	input wire logic [7:0][7:0] ext_pin_i,
	input wire logic write_strobe_n_i,
	input wire logic write_strobe_n_oe_i,
	output logic slow_clk_o,
	output logic fast_clk_o,
	output logic [7:0][7:0] pin_in_o,
	output logic write_strobe_n_o
);
	logic [1:0] div;
	// slow input kept at a quarter of the fast rate
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div <= 2'h0;
			slow_clk_o <= 1'b0;
			fast_clk_o <= 1'b0;
		end else begin
			div <= div + 2'h1;
			if (div == 2'h3)
				slow_clk_o <= !slow_clk_o;
			fast_clk_o <= fast_osc_i && !fast_clk_o;
		end
	end
	assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_pin_i);
	// emulator owns the strobe while released; otherwise the mux drives it when enabled, else pull-up
	assign write_strobe_n_o = !bus_release_in_i ? dma_write_n_i :
		write_strobe_n_oe_i ? write_strobe_n_i : 1'b1;
endmodule : pfc_far_side

/* File: pfc_pin_mux_bench.sv */
// pfc_pin_mux_bench: directed checks of pin functions, strobe, activity
// and clock control; assumes pfc_far_side stands on the pin side.
`timescale 1ns/1ns
module pfc_pin_mux_bench;
	logic ref_clk_i, rst_n_i, bus_release_in_i, dma_write_n;
	pfc_pkg::pfc_ctrl_t ctrl;
	pfc_pkg::pfc_core_t core;
	pfc_pkg::pfc_alt_in_t alt;
	logic [7:0][7:0] gpio_out, gpio_dir, pin_in, ext, pin_out, pin_oe;
	logic [7:0][7:0] gpio_in;
	logic slow_clk, fast_clk, fast_osc, strobe_pin, strobe_n, strobe_oe;
	logic activity, phase, halted, restart, strap, ready, prev;
	logic [1:0] tone;
	int bad_count = 0;
	int checked = 0;
	int n;
	pfc_pin_mux #(.SETTLE_CYCLES(16)) i_dut (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .ctrl_i(ctrl), .core_i(core),
		.gpio_out_i(gpio_out), .gpio_dir_i(gpio_dir), .pin_in_i(pin_in),
		.bus_release_in_i(bus_release_in_i), .slow_clk_i(slow_clk),
		.fast_clk_i(fast_clk), .write_strobe_n_i(strobe_pin),
		.pin_out_o(pin_out), .pin_oe_o(pin_oe), .gpio_in_o(gpio_in),
		.alt_o(alt),
		.tone_pin_o(tone), .write_strobe_n_o(strobe_n),
		.write_strobe_n_oe_o(strobe_oe), .activity_o(activity),
		.system_phase_clock_o(phase), .fast_osc_o(fast_osc),
		.fast_osc_ready_o(ready), .clock_restart_req_o(restart),
		.cpu_halted_o(halted), .boot_strap_o(strap));
	pfc_far_side i_far (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.fast_osc_i(fast_osc), .bus_release_in_i(bus_release_in_i),
		.dma_write_n_i(dma_write_n), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
		.ext_pin_i(ext), .write_strobe_n_i(strobe_n),
		.write_strobe_n_oe_i(strobe_oe), .slow_clk_o(slow_clk),
		.fast_clk_o(fast_clk), .pin_in_o(pin_in), .write_strobe_n_o(strobe_pin));
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	task end_sim;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task settle(input int k);
		repeat (k) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask : settle
	task do_reset(input logic rel);
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		bus_release_in_i <= rel;
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		settle(1);
		chk("reset restart", 1'b1, restart);
		settle(0);
	endtask : do_reset
	// instruction is only taken in a high phase, so hold it until seen
	task hold_until_halted;
		n = 0;
		while (halted !== 1'b1) begin
			@(negedge ref_clk_i);
			n++;
			if (n > 50) begin
				chk("halt wait", 1'b1, halted);
				end_sim();
			end
		end
		@(posedge ref_clk_i);
		core.wait_for_interrupt_instr <= 1'b0;
		core.halt_instr <= 1'b0;
	endtask : hold_until_halted
	initial begin
		rst_n_i = 1'b0;
		bus_release_in_i = 1'b1;
		dma_write_n = 1'b1;
		ctrl = '0;
		core = '0;
		core.chip_select_n = 8'hff;
		core.host_interrupt_n = 1'b1;
		gpio_out = '0;
		gpio_dir = '0;
		ext = '1;
		do_reset(1'b1);
		chk("osc off", 2'h0, {fast_osc, ready});
		@(posedge ref_clk_i);
		gpio_out[0] <= 8'h5a;
		gpio_dir[0] <= 8'h0f;
		core.addr <= 24'h3a5c71;
		core.ext_access <= 1'b1;
		ext[2] <= 8'hc3;
		settle(1);
		chk("p0", 16'h5a0f, {pin_out[0], pin_oe[0]});
		@(posedge ref_clk_i);
		ctrl.ext_bus_select <= 1'b1;
		settle(1);
		chk("addr", 24'h3a5c71, {pin_out[3], pin_out[1], pin_out[0]});
		chk("gpio in", 8'hfa, gpio_in[0]);
		chk("data in", 8'hc3, alt.bus_data_in);
		@(posedge ref_clk_i);
		ctrl.chip_select_enable <= 8'ha5;
		core.chip_select_n <= 8'h0f;
		gpio_out[7] <= 8'h33;
		settle(1);
		chk("p7", 8'h17, pin_out[7]);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_i);
			{ctrl.tone1_pin_enable, ctrl.tone0_pin_enable} <= i[1:0];
			{core.tone_out_1, core.tone_out_0} <= 2'h3;
			ext[4] <= 8'h00;
			ext[5] <= 8'h40;
			ext[6] <= 8'h04;
			{ctrl.p40_alt_enable, ctrl.p40_nonmask_choice} <= i[1:0];
			ctrl.level_irq_pin_enable <= i[0];
			ctrl.edge_enable_bit0 <= i[0];
			ctrl.edge_enable_bit1 <= i[0];
			ctrl.serial_rx_pin_enable[0] <= i[0];
			settle(1);
			chk("tone", i[1:0], tone);
			chk("nmi", i != 3, alt.nonmaskable_irq_n);
			chk("abort", i != 2, alt.abort_in_n);
			chk("irq", !i[0], alt.level_irq_n);
			chk("edge", i[0], alt.rising_edge_irq_in);
			chk("fall", !i[0], alt.falling_edge_irq_in[0]);
			chk("rx0", !i[0], alt.serial_receive[0]);
		end
		@(posedge ref_clk_i);
		ctrl.serial_tx_pin_enable[0] <= 1'b1;
		{ctrl.pwm_enable_a, ctrl.pwm_enable_b} <= 2'h3;
		core.timer_event_out <= 1'b1;
		settle(1);
		chk("tx0", 2'h1, {pin_out[6][1], pin_oe[6][1]});
		chk("pwm", 1'b1, alt.pwm_in);
		@(posedge ref_clk_i);
		ctrl.timer_output_pin_enable <= 1'b1;
		ctrl.host_port_enable <= 1'b1;
		core.host_interrupt_n <= 1'b0;
		ext[4] <= 8'hb0;
		ext[5] <= 8'h96;
		settle(1);
		chk("timer_event_out", 1'b1, pin_out[6][1]);
		chk("host int", 2'h1, {pin_out[4][2], pin_oe[4][2]});
		chk("host in", 11'h4b5, {alt.host_data_in, alt.host_reg_select});
		chk("host we", 2'h1, {alt.host_write_enable_n, alt.host_select_n});
		@(posedge ref_clk_i);
		ctrl.host_port_strobe_mode <= 1'b1;
		settle(1);
		chk("host rw", 4'h7, {alt.host_write_strobe_n, alt.host_read_strobe_n,
			alt.host_write_enable_n, alt.host_select_n});
		@(posedge ref_clk_i);
		ctrl.host_port_enable <= 1'b0;
		core.mem_write <= 1'b1;
		core.ext_access <= 1'b0;
		settle(1);
		chk("strobe int", 2'h3, {strobe_n, strobe_oe});
		@(posedge ref_clk_i);
		core.ext_access <= 1'b1;
		settle(1);
		chk("strobe ext", 2'h1, {strobe_n, strobe_oe});
		@(posedge ref_clk_i);
		bus_release_in_i <= 1'b0;
		dma_write_n <= 1'b0;
		settle(1);
		chk("dma", 2'h0, {strobe_oe, alt.dma_write_n});
		for (int t = 2; t >= 0; t--) begin
			@(posedge ref_clk_i);
			ctrl.emulation_trace_select <= t != 0;
			core.opcode_fetch <= t[1];
			bus_release_in_i <= t[0];
			dma_write_n <= 1'b1;
			core.mem_write <= 1'b0;
			settle(2);
			n = 0;
			repeat (16) begin
				@(negedge ref_clk_i);
				n += !activity;
			end
			chk("fetch low", t == 1, n > 0);
		end
		@(posedge ref_clk_i);
		bus_release_in_i <= 1'b1;
		core.wait_for_interrupt_instr <= 1'b1;
		hold_until_halted();
		settle(4);
		chk("wait", 2'h1, {activity, halted});
		@(posedge ref_clk_i);
		core.irq_wake <= 1'b1;
		@(posedge ref_clk_i);
		core.irq_wake <= 1'b0;
		@(negedge ref_clk_i);
		chk("wake", 3'h5, {activity, halted, restart});
		@(posedge ref_clk_i);
		ctrl.fast_osc_run_bit <= 1'b1;
		settle(1);
		chk("osc on", 1'b1, fast_osc);
		settle(18);
		chk("osc ready", 1'b1, ready);
		for (int s = 1; s >= 0; s--) begin
			@(posedge ref_clk_i);
			ctrl.clock_source_select <= s[0];
			settle(24);
			n = 0;
			prev = phase;
			repeat (8) begin
				@(negedge ref_clk_i);
				n += (phase != prev);
				prev = phase;
			end
			chk("phase rate", s[0] ? 8 : 2, n);
		end
		@(posedge ref_clk_i);
		core.halt_instr <= 1'b1;
		hold_until_halted();
		core.irq_wake <= 1'b1;
		settle(8);
		chk("stop", 3'h3, {activity, halted, phase});
		@(posedge ref_clk_i);
		core.irq_wake <= 1'b0;
		do_reset(1'b1);
		chk("restart", 2'h2, {activity, halted});
		do_reset(1'b0);
		chk("strap", 1'b1, strap);
		@(posedge ref_clk_i);
		ctrl.ext_bus_select <= 1'b0;
		bus_release_in_i <= 1'b1;
		settle(2);
		chk("strap bus", 8'hff, pin_oe[0]);
		end_sim();
	end
endmodule : pfc_pin_mux_bench
